// ==== rtl/vfm_defines.svh ====
`ifndef VFM_DEFINES_SVH
`define VFM_DEFINES_SVH

// ==========================================================================
// Holding register addresses (each value spans two 16-bit registers)
`define VFM_ADDR_OP_MAX 16'h6A00
`define VFM_ADDR_OP_MIN 16'h6A02
`define VFM_ADDR_OP_THR 16'h6A04
`define VFM_ADDR_WARN_UP 16'h6A06
`define VFM_ADDR_WARN_LW 16'h6A08
`define VFM_ADDR_WARN_THR 16'h6A0A
`define VFM_ADDR_VOL_A1 16'h6A0C
`define VFM_ADDR_VOL_A2 16'h6A0E
`define VFM_ADDR_VOL_B 16'h6A10

// ==========================================================================
// Reset values
`define VFM_THR_RESET 32'h0000_0003
`define VFM_POS_LIMIT 32'h7F80_0000
`define VFM_NEG_LIMIT 32'hFF80_0000
`define VFM_ZERO_WORD 32'h0000_0000

// ==========================================================================
// Flag positions and timing
`define VFM_WARN_BIT 2
`define VFM_SOFT_BIT 9
`define VFM_TICK_LAST 2'h3
`define VFM_TICK_GAP 7

`endif

// ==== rtl/vfm_pkg.sv ====
package vfm_pkg;

    // One pair of limits with its integrator threshold
    typedef struct packed {
        logic [31:0] upper;
        logic [31:0] lower;
        logic [31:0] threshold;
    } limit_set_t;

    // All holding registers of the block
    typedef struct packed {
        limit_set_t op;
        limit_set_t warn;
        logic [31:0] vol_a1;
        logic [31:0] vol_a2;
        logic [31:0] vol_b;
    } regs_t;

endpackage

// ==== rtl/limit_integrator.sv ====
`timescale 1ns/100ps

module limit_integrator #(
    parameter int CNT_W = 32
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic violation,
    input wire logic [CNT_W-1:0] threshold,
    output logic flag
);

    // ======================================================================
    // Consecutive violation counter
    logic [CNT_W-1:0] cnt_reg; // Run length of violations
    logic [CNT_W-1:0] cnt_next;
    logic flag_next;

    // Count on each measurement tick, restart on a clean one
    always_comb begin
        cnt_next = cnt_reg;
        flag_next = flag;
        if (tick) begin
            if (violation) begin
                // Saturate so a long fault never wraps back to clean
                if (cnt_reg != {CNT_W{1'b1}}) begin
                    cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end else begin
                cnt_next = '0;
            end
            // Threshold zero behaves as one
            flag_next = violation && (cnt_next >= threshold);
        end
    end

    // Registers only
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
            flag <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            flag <= flag_next;
        end
    end

    // ======================================================================
    // Checks
    property p_flag_needs_run;
        @(posedge ref_clk) disable iff (reset)
        $rose(flag) |-> (cnt_reg >= $past(threshold)) && (cnt_reg != '0);
    endproperty
    a_flag_needs_run: assert property (p_flag_needs_run) else $error("flag without enough violations");

    property p_clean_tick_clears;
        @(posedge ref_clk) disable iff (reset)
        tick && !violation |=> (cnt_reg == '0) && !flag;
    endproperty
    a_clean_tick_clears: assert property (p_clean_tick_clears) else $error("clean tick kept count");

endmodule // limit_integrator

// ==== rtl/volume_flow_limit_monitor.sv ====
// Functional notes
// - Flow above upper warning limit raises warning bit2
// - Flow below lower warning limit raises warning bit2
// - Warning needs threshold consecutive ticks, default three
// - Flow above range maximum raises soft error bit9
// - Flow below range minimum raises soft error bit9
// - Range fault needs threshold consecutive ticks, default three
// - Limits reset to extremes, no warning by default
// - Limits and flow share the selected unit
// - Correction volumes reachable only with special function
// - Range limits service only, warning limits user
// - Flow forced to zero without density source
`timescale 1ns/100ps
`include "vfm_defines.svh"

module volume_flow_limit_monitor #(
    parameter int CNT_W = 32
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic sensor_freq_in,
    input wire logic density_ok,
    input wire logic special_function_1,
    input wire logic service_level,
    input wire logic [31:0] flow_rate,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic reg_ack,
    output logic reg_err,
    output logic [31:0] reg_rdata,
    output logic [31:0] vol_flow_out,
    output logic [31:0] warnings_flags,
    output logic [31:0] soft_error_flags
);

    // ======================================================================
    // Float ordering
    // Maps IEEE single to an unsigned key that sorts like the value
    function automatic logic [31:0] order_key(input logic [31:0] f);
        order_key = f[31] ? ~f : (f | 32'h8000_0000);
    endfunction

    // ======================================================================
    // Sensor frequency sync and divide by four
    logic sync1_reg, sync2_reg, sync3_reg; // Synchroniser and edge history
    logic [1:0] div_reg; // Sensor edge count
    logic [1:0] div_next;
    logic meas_tick; // One measurement cycle
    logic sensor_edge;

    assign sensor_edge = sync2_reg && !sync3_reg;
    assign meas_tick = sensor_edge && (div_reg == `VFM_TICK_LAST);

    // Divider next value
    always_comb begin
        div_next = div_reg;
        if (sensor_edge) begin
            div_next = div_reg + 2'h1;
        end
    end

    // Divider and sync registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            div_reg <= 2'h0;
        end else begin
            sync1_reg <= sensor_freq_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            div_reg <= div_next;
        end
    end

    // ======================================================================
    // Flow value
    logic [31:0] vol_flow_next;

    // Zero flow without a density source
    always_comb begin
        vol_flow_next = density_ok ? flow_rate : `VFM_ZERO_WORD;
    end

    // Flow register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            vol_flow_out <= `VFM_ZERO_WORD;
        end else begin
            vol_flow_out <= vol_flow_next;
        end
    end

    // ======================================================================
    // Holding registers
    vfm_pkg::regs_t regs_reg; // Stored limits and volumes
    vfm_pkg::regs_t regs_next;
    logic ack_next, err_next;
    logic [31:0] rdata_next;
    logic access;

    assign access = reg_wr || reg_rd;

    // Address decode and write effects
    always_comb begin
        regs_next = regs_reg;
        ack_next = access;
        err_next = 1'b0;
        rdata_next = reg_rdata;
        if (!access) begin
            rdata_next = reg_rdata; // Idle, hold last answer
        end else if (reg_addr == `VFM_ADDR_OP_MAX) begin
            rdata_next = regs_reg.op.upper;
            if (reg_wr && service_level) regs_next.op.upper = reg_wdata;
            else if (reg_wr) err_next = 1'b1;
        end else if (reg_addr == `VFM_ADDR_OP_MIN) begin
            rdata_next = regs_reg.op.lower;
            if (reg_wr && service_level) regs_next.op.lower = reg_wdata;
            else if (reg_wr) err_next = 1'b1;
        end else if (reg_addr == `VFM_ADDR_OP_THR) begin
            rdata_next = regs_reg.op.threshold;
            if (reg_wr && service_level) regs_next.op.threshold = reg_wdata;
            else if (reg_wr) err_next = 1'b1;
        end else if (reg_addr == `VFM_ADDR_WARN_UP) begin
            rdata_next = regs_reg.warn.upper;
            if (reg_wr) regs_next.warn.upper = reg_wdata;
        end else if (reg_addr == `VFM_ADDR_WARN_LW) begin
            rdata_next = regs_reg.warn.lower;
            if (reg_wr) regs_next.warn.lower = reg_wdata;
        end else if (reg_addr == `VFM_ADDR_WARN_THR) begin
            rdata_next = regs_reg.warn.threshold;
            if (reg_wr) regs_next.warn.threshold = reg_wdata;
        end else if (!special_function_1 && (reg_addr == `VFM_ADDR_VOL_A1 ||
                     reg_addr == `VFM_ADDR_VOL_A2 || reg_addr == `VFM_ADDR_VOL_B)) begin
            err_next = 1'b1;
            rdata_next = `VFM_ZERO_WORD;
        end else if (reg_addr == `VFM_ADDR_VOL_A1) begin
            rdata_next = regs_reg.vol_a1;
            if (reg_wr) regs_next.vol_a1 = reg_wdata;
        end else if (reg_addr == `VFM_ADDR_VOL_A2) begin
            rdata_next = regs_reg.vol_a2;
            if (reg_wr) regs_next.vol_a2 = reg_wdata;
        end else if (reg_addr == `VFM_ADDR_VOL_B) begin
            rdata_next = regs_reg.vol_b;
            if (reg_wr) regs_next.vol_b = reg_wdata;
        end else begin
            err_next = 1'b1; // Unmapped address
            rdata_next = `VFM_ZERO_WORD;
        end
    end

    // Register file, limits open wide at reset
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            regs_reg.op.upper <= `VFM_POS_LIMIT;
            regs_reg.op.lower <= `VFM_NEG_LIMIT;
            regs_reg.op.threshold <= `VFM_THR_RESET;
            regs_reg.warn.upper <= `VFM_POS_LIMIT;
            regs_reg.warn.lower <= `VFM_NEG_LIMIT;
            regs_reg.warn.threshold <= `VFM_THR_RESET;
            regs_reg.vol_a1 <= `VFM_ZERO_WORD;
            regs_reg.vol_a2 <= `VFM_ZERO_WORD;
            regs_reg.vol_b <= `VFM_ZERO_WORD;
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
            reg_rdata <= `VFM_ZERO_WORD;
        end else begin
            regs_reg <= regs_next;
            reg_ack <= ack_next;
            reg_err <= err_next;
            reg_rdata <= rdata_next;
        end
    end

    // ======================================================================
    // Limit comparison
    // Flow and limits are both in the selected unit, compared as given
    logic warn_viol, op_viol; // Present violation per limit pair
    logic warn_flag, op_flag; // Integrated flags
    logic [31:0] flow_key;

    assign flow_key = order_key(vol_flow_out);
    assign warn_viol = (flow_key > order_key(regs_reg.warn.upper)) ||
                       (flow_key < order_key(regs_reg.warn.lower));
    assign op_viol = (flow_key > order_key(regs_reg.op.upper)) ||
                     (flow_key < order_key(regs_reg.op.lower));

    // Warning integrator
    limit_integrator #(.CNT_W(CNT_W)) u_warn_int (
        .ref_clk(ref_clk),
        .reset(reset),
        .tick(meas_tick),
        .violation(warn_viol),
        .threshold(regs_reg.warn.threshold[CNT_W-1:0]),
        .flag(warn_flag)
    );

    // Operating range integrator
    limit_integrator #(.CNT_W(CNT_W)) u_op_int (
        .ref_clk(ref_clk),
        .reset(reset),
        .tick(meas_tick),
        .violation(op_viol),
        .threshold(regs_reg.op.threshold[CNT_W-1:0]),
        .flag(op_flag)
    );

    // Flag words, other bits belong to other blocks
    always_comb begin
        warnings_flags = `VFM_ZERO_WORD;
        soft_error_flags = `VFM_ZERO_WORD;
        warnings_flags[`VFM_WARN_BIT] = warn_flag;
        soft_error_flags[`VFM_SOFT_BIT] = op_flag;
    end

    // ======================================================================
    // Checks
    sequence s_user_write_range;
        reg_wr && !service_level && (reg_addr == `VFM_ADDR_OP_MAX);
    endsequence

    sequence s_hidden_volume;
        access && !special_function_1 && (reg_addr == `VFM_ADDR_VOL_B);
    endsequence

    property p_zero_flow;
        @(posedge ref_clk) disable iff (reset)
        !density_ok |=> vol_flow_out == `VFM_ZERO_WORD;
    endproperty
    a_zero_flow: assert property (p_zero_flow) else $error("flow not zeroed");

    property p_range_refused;
        @(posedge ref_clk) disable iff (reset)
        s_user_write_range |=> reg_err && reg_ack && $stable(regs_reg.op.upper);
    endproperty
    a_range_refused: assert property (p_range_refused) else $error("user changed range limit");

    property p_warn_write;
        @(posedge ref_clk) disable iff (reset)
        reg_wr && (reg_addr == `VFM_ADDR_WARN_UP) |=> !reg_err && (regs_reg.warn.upper == $past(reg_wdata));
    endproperty
    a_warn_write: assert property (p_warn_write) else $error("warning limit write lost");

    property p_hidden_volume;
        @(posedge ref_clk) disable iff (reset)
        s_hidden_volume |=> reg_err && (reg_rdata == `VFM_ZERO_WORD);
    endproperty
    a_hidden_volume: assert property (p_hidden_volume) else $error("volume reachable without function");

    property p_tick_gap;
        @(posedge ref_clk) disable iff (reset)
        meas_tick |=> !meas_tick [*7];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");

    property p_warn_rise;
        @(posedge ref_clk) disable iff (reset)
        $rose(warn_flag) |-> $past(meas_tick) && $past(warn_viol);
    endproperty
    a_warn_rise: assert property (p_warn_rise) else $error("warning without violation tick");

    property p_op_clear;
        @(posedge ref_clk) disable iff (reset)
        meas_tick && !op_viol |=> !soft_error_flags[`VFM_SOFT_BIT];
    endproperty
    a_op_clear: assert property (p_op_clear) else $error("range fault held after clean tick");

    property p_default_quiet;
        @(posedge ref_clk) disable iff (reset)
        (regs_reg.op.upper == `VFM_POS_LIMIT) && (regs_reg.op.lower == `VFM_NEG_LIMIT) && !op_viol [*2]
        |-> !soft_error_flags[`VFM_SOFT_BIT] || $past(op_flag);
    endproperty
    a_default_quiet: assert property (p_default_quiet) else $error("default limits raised fault");

endmodule // volume_flow_limit_monitor

// ==== tb/flow_sensor_model.sv ====
`timescale 1ns/100ps

// ==========================================================================
// Flow sensor source driving the frequency pin
module flow_sensor_model (
    input wire logic ref_clk,
    output logic sensor_freq_in
);

    // Pin idles low between bursts
    initial begin
        sensor_freq_in = 1'b0;
    end

    // Sends n measurement cycles of four pin periods each
    task automatic send(input int n);
        for (int i = 0; i < 4 * n; i++) begin
            repeat (3) @(posedge ref_clk);
            #1 sensor_freq_in = 1'b1;
            repeat (3) @(posedge ref_clk);
            #1 sensor_freq_in = 1'b0;
        end
        // Margin for synchroniser, tick and flag update
        repeat (6) @(posedge ref_clk);
    endtask

endmodule // flow_sensor_model

// ==== tb/volume_flow_limit_monitor_tb.sv ====
`timescale 1ns/100ps
`include "vfm_defines.svh"

// ==========================================================================
// Register access and limit integration checks
module volume_flow_limit_monitor_tb;

    logic ref_clk = 1'b0; // Bench clock
    logic reset = 1'b1; // Held at start
    logic sensor_freq_in; // From sensor model
    logic density_ok = 1'b1; // Density source present
    logic special_function_1 = 1'b0; // Correction volumes gate
    logic service_level = 1'b0; // Access level
    logic [31:0] flow_rate = 32'h0000_0000; // Flow input
    logic reg_wr = 1'b0; // Write request
    logic reg_rd = 1'b0; // Read request
    logic [15:0] reg_addr = 16'h0000; // Register address
    logic [31:0] reg_wdata = 32'h0000_0000; // Write data
    logic reg_ack; // Answer pulse
    logic reg_err; // Refusal mark
    logic [31:0] reg_rdata; // Read data
    logic [31:0] vol_flow_out; // Registered flow
    logic [31:0] warnings_flags; // Warning flags
    logic [31:0] soft_error_flags; // Soft error flags
    int fail_count = 0; // Mismatches
    int comparisons = 0; // Compares made
    logic [15:0] ra [9]; // Address table
    logic [31:0] rv [9]; // Reset value table

    // 50 MHz clock
    always begin
        #10 ref_clk = ~ref_clk;
    end

    // ======================================================================
    // Instances
    volume_flow_limit_monitor #(.CNT_W(32)) uut (
        .ref_clk(ref_clk),
        .reset(reset),
        .sensor_freq_in(sensor_freq_in),
        .density_ok(density_ok),
        .special_function_1(special_function_1),
        .service_level(service_level),
        .flow_rate(flow_rate),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_ack(reg_ack),
        .reg_err(reg_err),
        .reg_rdata(reg_rdata),
        .vol_flow_out(vol_flow_out),
        .warnings_flags(warnings_flags),
        .soft_error_flags(soft_error_flags)
    );

    flow_sensor_model sensor (
        .ref_clk(ref_clk),
        .sensor_freq_in(sensor_freq_in)
    );

    // ======================================================================
    // Tasks
    // Compares and counts
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One request pulse; answer stands just after the taking edge
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        #1;
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        check({31'h0, reg_ack}, 32'h1);
    endtask

    // Write with expected refusal mark
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
        bus(1'b1, a, d);
        check({31'h0, reg_err}, {31'h0, e});
    endtask

    // Read with expected data and refusal mark
    task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic e);
        bus(1'b0, a, 32'h0000_0000);
        check({31'h0, reg_err}, {31'h0, e});
        check(reg_rdata, x);
    endtask

    // Measurement cycles from the sensor
    task automatic ticks(input int n);
        sensor.send(n);
        #1;
    endtask

    // Verdict and end of run
    task automatic results;
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #2000000;
        fail_count++;
        results();
    end

    // ======================================================================
    // Main sequence
    initial begin
        ra = '{`VFM_ADDR_OP_MAX, `VFM_ADDR_OP_MIN, `VFM_ADDR_OP_THR, `VFM_ADDR_WARN_UP, `VFM_ADDR_WARN_LW,
               `VFM_ADDR_WARN_THR, `VFM_ADDR_VOL_A1, `VFM_ADDR_VOL_A2, `VFM_ADDR_VOL_B};
        rv = '{`VFM_POS_LIMIT, `VFM_NEG_LIMIT, `VFM_THR_RESET, `VFM_POS_LIMIT, `VFM_NEG_LIMIT,
               `VFM_THR_RESET, `VFM_ZERO_WORD, `VFM_ZERO_WORD, `VFM_ZERO_WORD};
        repeat (4) @(posedge ref_clk);
        #1 reset = 1'b0;
        special_function_1 = 1'b1;
        check(warnings_flags, 32'h0000_0000);
        check(soft_error_flags, 32'h0000_0000);
        // Reset values of every register
        for (int i = 0; i < 9; i++) begin
            rd(ra[i], rv[i], 1'b0);
        end
        // Correction volumes with and without the special function
        for (int i = 6; i < 9; i++) begin
            wr(ra[i], 32'h4000_0000 + i, 1'b0);
            rd(ra[i], 32'h4000_0000 + i, 1'b0);
        end
        special_function_1 = 1'b0;
        rd(`VFM_ADDR_VOL_A1, 32'h0000_0000, 1'b1);
        wr(`VFM_ADDR_VOL_B, 32'h0000_0001, 1'b1);
        special_function_1 = 1'b1;
        rd(`VFM_ADDR_VOL_B, 32'h4000_0008, 1'b0);
        // Unmapped place
        rd(16'h6A12, 32'h0000_0000, 1'b1);
        wr(16'h6A12, 32'h0000_0001, 1'b1);
        // Access levels
        wr(`VFM_ADDR_OP_MAX, 32'h3F80_0000, 1'b1);
        rd(`VFM_ADDR_OP_MAX, `VFM_POS_LIMIT, 1'b0);
        wr(`VFM_ADDR_WARN_UP, 32'h3F80_0000, 1'b0);
        rd(`VFM_ADDR_WARN_UP, 32'h3F80_0000, 1'b0);
        // Upper warning needs three cycles
        flow_rate = 32'h4000_0000;
        ticks(2);
        check(warnings_flags, 32'h0000_0000);
        ticks(1);
        check(warnings_flags, 32'h0000_0004);
        check(soft_error_flags, 32'h0000_0000);
        flow_rate = 32'h3F00_0000;
        ticks(1);
        check(warnings_flags, 32'h0000_0000);
        // Lower warning with an interrupted run
        wr(`VFM_ADDR_WARN_LW, 32'hBF00_0000, 1'b0);
        flow_rate = 32'hBF80_0000;
        ticks(2);
        flow_rate = 32'h0000_0000;
        ticks(1);
        flow_rate = 32'hBF80_0000;
        ticks(2);
        check(warnings_flags, 32'h0000_0000);
        ticks(1);
        check(warnings_flags, 32'h0000_0004);
        // Programmed threshold of five
        flow_rate = 32'h0000_0000;
        ticks(1);
        wr(`VFM_ADDR_WARN_THR, 32'h0000_0005, 1'b0);
        flow_rate = 32'hBF80_0000;
        ticks(4);
        check(warnings_flags, 32'h0000_0000);
        ticks(1);
        check(warnings_flags, 32'h0000_0004);
        // Operating range at service level, default threshold then one
        service_level = 1'b1;
        wr(`VFM_ADDR_OP_MAX, 32'h3F80_0000, 1'b0);
        wr(`VFM_ADDR_OP_MIN, 32'h3F00_0000, 1'b0);
        flow_rate = 32'h4000_0000;
        ticks(2);
        check(soft_error_flags, 32'h0000_0000);
        ticks(1);
        check(soft_error_flags, 32'h0000_0200);
        wr(`VFM_ADDR_OP_THR, 32'h0000_0001, 1'b0);
        flow_rate = 32'h3F40_0000;
        ticks(1);
        check(soft_error_flags, 32'h0000_0000);
        flow_rate = 32'h4000_0000;
        ticks(1);
        check(soft_error_flags, 32'h0000_0200);
        flow_rate = 32'h3E80_0000;
        ticks(1);
        check(soft_error_flags, 32'h0000_0200);
        check(vol_flow_out, 32'h3E80_0000);
        // Flow forced to zero without density
        density_ok = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check(vol_flow_out, 32'h0000_0000);
        density_ok = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        check(vol_flow_out, 32'h3E80_0000);
        // Mid-run reset restores open limits and clears flags
        reset = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 reset = 1'b0;
        check(soft_error_flags, 32'h0000_0000);
        check(warnings_flags, 32'h0000_0000);
        rd(`VFM_ADDR_OP_MAX, `VFM_POS_LIMIT, 1'b0);
        rd(`VFM_ADDR_OP_THR, `VFM_THR_RESET, 1'b0);
        rd(`VFM_ADDR_WARN_THR, `VFM_THR_RESET, 1'b0);
        results();
    end

endmodule // volume_flow_limit_monitor_tb
